// >>> gld_attr_dec.sv
// Decoder of a text attribute byte into reverse, inhibit and blink.
// Assumes the byte comes from the graphic area; undefined codes show as normal.
`timescale 1ns/1ps
module gld_attr_dec (
   input  wire logic [7:0] attr,      // Attribute byte, upper nibble ignored
   output      logic       reverse,   // Show inverted
   output      logic       inhibit,   // Show blank
   output      logic       blink      // Blink the character
);
   always_comb begin
      reverse = attr[2] & ~attr[1] & attr[0];
      inhibit = ~attr[2] & attr[1] & attr[0];
      blink   = attr[3] & (reverse | inhibit | (attr[2:0] == 3'b000));
   end
endmodule : gld_attr_dec

// >>> gld_cmd_decoder.sv
// Command decoder of a dot-matrix graphic display controller.
// Assumes a host byte port (data / command-status) and a display RAM with one-cycle read latency.
`timescale 1ns/1ps
module gld_cmd_decoder (
   input  wire logic                  core_clk,             // Clock, 25 MHz
   input  wire logic                  nrst,                 // Asynchronous reset, active low
   input  wire logic                  bus_addr,             // 0 data, 1 command/status
   input  wire logic [7:0]            bus_wdata,            // Write byte
   input  wire logic                  bus_wr,               // Write strobe
   input  wire logic                  bus_rd,               // Read strobe
   output      logic [7:0]            bus_rdata,            // Read byte, cycle after strobe
   output      gld_pkg::gld_ram_req_t ram_req,              // Display RAM request
   input  wire logic [7:0]            ram_rdata,            // RAM byte, one cycle after re
   input  wire logic [7:0]            cg_pattern,           // Character pattern row for the cell
   input  wire logic [7:0]            fixed_column_count,   // Columns set by pins
   input  wire logic [7:0]            display_rows,         // Rows on the panel
   input  wire logic                  dual_screen,          // Two-screen drive strap
   input  wire logic [7:0]            scan_row,             // Zero-based row being scanned
   output      gld_pkg::gld_cfg_t     cfg,                  // Display configuration
   output      logic [15:0]           text_row_base,        // Start of scanned text row
   output      logic [15:0]           graphic_row_base,     // Start of scanned graphic row
   output      logic [15:0]           display_ram_pointer,  // Address pointer
   output      logic                  auto_read_ready_flag, // Auto read byte ready
   output      logic                  auto_write_ready_flag,// Auto write accepts a byte
   output      logic                  peek_copy_error_flag  // Peek outside graphic area
);

   typedef struct packed {
      gld_pkg::gld_st_t      st;
      gld_pkg::gld_op_t      op;
      gld_pkg::gld_cfg_t     cfg;
      gld_pkg::gld_ram_req_t ram;
      logic [15:0]           ptr;
      logic [7:0]            op0;
      logic [7:0]            op1;
      logic                  auto_wr;
      logic                  auto_rd;
      logic [7:0]            stack;
      logic                  stack_vld;
      logic                  peek_err;
      logic [3:0]            sub;
      logic [7:0]            cnt;
      logic [7:0]            rdata;
      logic [15:0]           tbase;
      logic [15:0]           gbase;
      logic                  ard_ok;
      logic                  awr_ok;
   } gld_state_t;

   gld_state_t  s_r;
   gld_state_t  s_nxt;
   logic [15:0] tbase_w;
   logic [15:0] gbase_w;
   logic [15:0] gend_w;
   logic        attr_rev;
   logic        attr_inh;
   logic [7:0]  txt_attr;
   logic [7:0]  shown;

   ////////////////////////////////////////////////////////////////////////////
   // Row addressing and attribute decode

   gld_row_addr u_text_row (
      .home   (s_r.cfg.text_home),
      .stride (s_r.cfg.text_stride),
      .row    (scan_row),
      .base   (tbase_w)
   );

   gld_row_addr u_gfx_row (
      .home   (s_r.cfg.gfx_home),
      .stride (s_r.cfg.gfx_stride),
      .row    (scan_row),
      .base   (gbase_w)
   );

   // First address past the graphic area bounds the peek window
   gld_row_addr u_gfx_end (
      .home   (s_r.cfg.gfx_home),
      .stride (s_r.cfg.gfx_stride),
      .row    (display_rows),
      .base   (gend_w)
   );

   // The graphic byte at the same offset is the attribute of the cell
   gld_attr_dec u_attr (
      .attr    (ram_rdata),
      .reverse (attr_rev),
      .inhibit (attr_inh),
      .blink   ()
   );

   always_comb begin
      txt_attr = attr_inh ? 8'h00 : (attr_rev ? ~cg_pattern : cg_pattern);
      shown    = gld_pkg::gld_combine(s_r.cfg, cg_pattern, txt_attr, ram_rdata);
   end

   ////////////////////////////////////////////////////////////////////////////
   // Next state

   always_comb begin
      logic       idle;
      logic [7:0] c;
      logic [7:0] mask;
      logic [7:0] nxt_cnt;
      idle    = (s_r.st == gld_pkg::ST_IDLE);
      c       = bus_wdata;
      mask    = 8'(8'h01 << s_r.sub[2:0]);
      nxt_cnt = s_r.cnt + 8'h01;
      s_nxt        = s_r;
      s_nxt.ram.we = 1'b0;
      s_nxt.ram.re = 1'b0;
      s_nxt.rdata  = 8'h00;
      s_nxt.tbase  = tbase_w;
      s_nxt.gbase  = gbase_w;

      // Host reads; data reads in auto read consume the stacked byte
      if (bus_rd) begin
         if (bus_addr == gld_pkg::ADDR_CMD) begin
            s_nxt.rdata[gld_pkg::STS_CMD_OK]  = idle;
            s_nxt.rdata[gld_pkg::STS_DATA_OK] = idle;
            s_nxt.rdata[gld_pkg::STS_ARD_OK]  = s_r.ard_ok;
            s_nxt.rdata[gld_pkg::STS_AWR_OK]  = s_r.awr_ok;
            s_nxt.rdata[gld_pkg::STS_ERR]     = s_r.peek_err;
         end else begin
            s_nxt.rdata = s_r.stack;
            if (s_r.auto_rd) begin
               s_nxt.stack_vld = 1'b0;
            end
         end
      end

      // Prefetch the next auto read byte while the stack is empty
      if (idle && s_r.auto_rd && !s_r.stack_vld) begin
         s_nxt.ram.re   = 1'b1;
         s_nxt.ram.addr = s_r.ptr;
         s_nxt.op       = gld_pkg::OP_AUTO;
         s_nxt.st       = gld_pkg::ST_RD1;
      end

      // Data writes: display data in auto write, operands outside both auto modes
      if (bus_wr && bus_addr == gld_pkg::ADDR_DATA) begin
         if (s_r.auto_wr) begin
            if (idle) begin
               s_nxt.ram.we    = 1'b1;
               s_nxt.ram.addr  = s_r.ptr;
               s_nxt.ram.wdata = bus_wdata;
               s_nxt.ptr       = s_r.ptr + 16'h0001;
            end
         end else if (!s_r.auto_rd) begin
            s_nxt.op0 = s_r.op1;
            s_nxt.op1 = bus_wdata;
         end
      end

      // Commands are taken only while idle; busy shows in the status
      if (bus_wr && bus_addr == gld_pkg::ADDR_CMD && idle) begin
         if (s_r.auto_wr || s_r.auto_rd) begin
            if (c == gld_pkg::CMD_AUTO_RS) begin
               s_nxt.auto_wr   = 1'b0;
               s_nxt.auto_rd   = 1'b0;
               s_nxt.stack_vld = 1'b0;
               s_nxt.ram.re    = 1'b0;
               s_nxt.st        = gld_pkg::ST_IDLE;
            end
         end else begin
            case (c[7:4])
               gld_pkg::GRP_REG: begin
                  if (c[3:0] == gld_pkg::SUB_CURSOR) begin
                     s_nxt.cfg.cursor_x = s_r.op0;
                     s_nxt.cfg.cursor_y = s_r.op1;
                  end else if (c[3:0] == gld_pkg::SUB_POINTER) begin
                     s_nxt.ptr = {s_r.op1, s_r.op0};
                  end
               end
               gld_pkg::GRP_CTRL: begin
                  if (c[3:2] == 2'b00) begin
                     case (c[1:0])
                        2'b00:   s_nxt.cfg.text_home   = {s_r.op1, s_r.op0};
                        2'b01:   s_nxt.cfg.text_stride = s_r.op0;
                        2'b10:   s_nxt.cfg.gfx_home    = {s_r.op1, s_r.op0};
                        default: s_nxt.cfg.gfx_stride  = s_r.op0;
                     endcase
                  end
               end
               gld_pkg::GRP_MODE: begin
                  s_nxt.cfg.cg_ext = c[3];
                  case (c[2:0])
                     3'b000:  s_nxt.cfg.comb = gld_pkg::CMB_OR;
                     3'b001:  s_nxt.cfg.comb = gld_pkg::CMB_XOR;
                     3'b011:  s_nxt.cfg.comb = gld_pkg::CMB_AND;
                     3'b100:  s_nxt.cfg.comb = gld_pkg::CMB_ATTR;
                     default: s_nxt.cfg.comb = s_r.cfg.comb;
                  endcase
               end
               gld_pkg::GRP_DISP: begin
                  s_nxt.cfg.blink_en  = c[0];
                  s_nxt.cfg.cursor_en = c[1];
                  s_nxt.cfg.text_en   = c[2];
                  s_nxt.cfg.gfx_en    = c[3];
               end
               gld_pkg::GRP_CURS: begin
                  if (!c[3]) begin
                     s_nxt.cfg.cursor_lines = c[2:0];
                  end
               end
               gld_pkg::GRP_AUTO: begin
                  if (c == gld_pkg::CMD_AUTO_WR) begin
                     s_nxt.auto_wr = 1'b1;
                  end else if (c == gld_pkg::CMD_AUTO_RD) begin
                     s_nxt.auto_rd   = 1'b1;
                     s_nxt.stack_vld = 1'b0;
                  end
               end
               gld_pkg::GRP_DATA: begin
                  if (!c[3] && c[2:1] != 2'b11) begin
                     s_nxt.sub = c[3:0];
                     if (c[0]) begin
                        s_nxt.ram.re   = 1'b1;
                        s_nxt.ram.addr = s_r.ptr;
                        s_nxt.op       = gld_pkg::OP_READ;
                        s_nxt.st       = gld_pkg::ST_RD1;
                     end else begin
                        s_nxt.ram.we    = 1'b1;
                        s_nxt.ram.addr  = s_r.ptr;
                        s_nxt.ram.wdata = s_r.op1;
                        case (c[2:1])
                           2'b00:   s_nxt.ptr = s_r.ptr + 16'h0001;
                           2'b01:   s_nxt.ptr = s_r.ptr - 16'h0001;
                           default: s_nxt.ptr = s_r.ptr;
                        endcase
                     end
                  end
               end
               gld_pkg::GRP_SCREEN: begin
                  if (c == gld_pkg::CMD_PEEK) begin
                     if (s_r.ptr >= s_r.cfg.gfx_home && s_r.ptr < gend_w) begin
                        s_nxt.ram.re   = 1'b1;
                        s_nxt.ram.addr = s_r.ptr;
                        s_nxt.op       = gld_pkg::OP_PEEK;
                        s_nxt.st       = gld_pkg::ST_RD1;
                        s_nxt.peek_err = 1'b0;
                     end else begin
                        s_nxt.peek_err = 1'b1;
                     end
                  end else if (c == gld_pkg::CMD_COPY) begin
                     if (s_r.cfg.comb != gld_pkg::CMB_ATTR && !dual_screen) begin
                        s_nxt.cnt = 8'h00;
                        s_nxt.op  = gld_pkg::OP_COPY;
                        s_nxt.st  = gld_pkg::ST_COPY;
                     end
                  end
               end
               gld_pkg::GRP_BIT: begin
                  s_nxt.sub      = c[3:0];
                  s_nxt.ram.re   = 1'b1;
                  s_nxt.ram.addr = s_r.ptr;
                  s_nxt.op       = gld_pkg::OP_BIT;
                  s_nxt.st       = gld_pkg::ST_RD1;
               end
               default: begin
               end
            endcase
         end
      end

      // Read sequencer for data read, auto read, bit change, peek and copy
      case (s_r.st)
         gld_pkg::ST_RD1: begin
            s_nxt.st = gld_pkg::ST_RD2;
         end
         gld_pkg::ST_RD2: begin
            s_nxt.st = gld_pkg::ST_IDLE;
            case (s_r.op)
               gld_pkg::OP_READ: begin
                  s_nxt.stack     = ram_rdata;
                  s_nxt.stack_vld = 1'b1;
                  case (s_r.sub[2:1])
                     2'b00:   s_nxt.ptr = s_r.ptr + 16'h0001;
                     2'b01:   s_nxt.ptr = s_r.ptr - 16'h0001;
                     default: s_nxt.ptr = s_r.ptr;
                  endcase
               end
               gld_pkg::OP_AUTO: begin
                  if (s_r.auto_rd) begin
                     s_nxt.stack     = ram_rdata;
                     s_nxt.stack_vld = 1'b1;
                     s_nxt.ptr       = s_r.ptr + 16'h0001;
                  end
               end
               gld_pkg::OP_BIT: begin
                  s_nxt.ram.we    = 1'b1;
                  s_nxt.ram.addr  = s_r.ptr;
                  s_nxt.ram.wdata = s_r.sub[3] ? (ram_rdata | mask) : (ram_rdata & ~mask);
               end
               gld_pkg::OP_PEEK: begin
                  s_nxt.stack     = shown;
                  s_nxt.stack_vld = 1'b1;
               end
               gld_pkg::OP_COPY: begin
                  s_nxt.ram.we    = 1'b1;
                  s_nxt.ram.addr  = s_r.ptr + {8'h00, s_r.cnt};
                  s_nxt.ram.wdata = shown;
                  s_nxt.cnt       = nxt_cnt;
                  if (nxt_cnt < fixed_column_count) begin
                     s_nxt.st = gld_pkg::ST_COPY;
                  end
               end
               default: begin
               end
            endcase
         end
         gld_pkg::ST_COPY: begin
            s_nxt.ram.re   = 1'b1;
            s_nxt.ram.addr = s_r.ptr + {8'h00, s_r.cnt};
            s_nxt.st       = gld_pkg::ST_RD1;
         end
         default: begin
         end
      endcase

      s_nxt.ard_ok = s_nxt.auto_rd & s_nxt.stack_vld;
      s_nxt.awr_ok = s_nxt.auto_wr & (s_nxt.st == gld_pkg::ST_IDLE);
   end

   ////////////////////////////////////////////////////////////////////////////
   // State register

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         s_r       <= '0;
         s_r.cfg   <= gld_pkg::CFG_RESET;
         s_r.ram   <= gld_pkg::RAM_IDLE;
         s_r.st    <= gld_pkg::ST_IDLE;
         s_r.op    <= gld_pkg::OP_READ;
      end else begin
         s_r <= s_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs, all straight from the state register

   always_comb begin
      bus_rdata             = s_r.rdata;
      ram_req               = s_r.ram;
      cfg                   = s_r.cfg;
      text_row_base         = s_r.tbase;
      graphic_row_base      = s_r.gbase;
      display_ram_pointer   = s_r.ptr;
      auto_read_ready_flag  = s_r.ard_ok;
      auto_write_ready_flag = s_r.awr_ok;
      peek_copy_error_flag  = s_r.peek_err;
   end

endmodule : gld_cmd_decoder

// >>> gld_cmd_decoder_props.sv
// Port checker of the command decoder, bound into every instance.
// Assumes the host polls status before commands, so commands are taken.
`timescale 1ns/1ps
module gld_cmd_decoder_props (
   input wire logic                  core_clk,              // Clock
   input wire logic                  nrst,                  // Reset, active low
   input wire logic                  bus_addr,              // Port location
   input wire logic [7:0]            bus_wdata,             // Write byte
   input wire logic                  bus_wr,                // Write strobe
   input wire logic [7:0]            scan_row,              // Scanned row
   input wire gld_pkg::gld_ram_req_t ram_req,               // RAM request
   input wire gld_pkg::gld_cfg_t     cfg,                   // Configuration
   input wire logic [15:0]           text_row_base,         // Text row start
   input wire logic [15:0]           graphic_row_base,      // Graphic row start
   input wire logic [15:0]           display_ram_pointer,   // Pointer
   input wire logic                  auto_read_ready_flag,  // Auto read flag
   input wire logic                  auto_write_ready_flag, // Auto write flag
   input wire logic                  peek_copy_error_flag   // Peek error
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!nrst);
   wire cmd = bus_wr && bus_addr;
   a_gfx_row_base: assert property (graphic_row_base == 16'($past(cfg.gfx_home) +
      $past(scan_row) * $past(cfg.gfx_stride))) else $error("graphic row base wrong");
   a_text_row_base: assert property (text_row_base == 16'($past(cfg.text_home) +
      $past(scan_row) * $past(cfg.text_stride))) else $error("text row base wrong");
   a_comb_hold: assert property ($changed(cfg.comb) |-> $past(cmd && bus_wdata[7:4] == 4'h8))
      else $error("combine mode changed without mode set");
   a_cgen_select: assert property ($changed(cfg.cg_ext) |-> $past(cmd && bus_wdata[7:4] == 4'h8)
      && cfg.cg_ext == $past(bus_wdata[3])) else $error("generator select wrong");
   a_disp_enables: assert property ($changed({cfg.gfx_en, cfg.text_en, cfg.cursor_en, cfg.blink_en})
      |-> $past(cmd && bus_wdata[7:4] == 4'h9)) else $error("display enables changed unasked");
   a_cursor_height: assert property ($changed(cfg.cursor_lines) |-> $past(cmd && bus_wdata[7:3] == 5'h14)
      && cfg.cursor_lines == $past(bus_wdata[2:0])) else $error("cursor height wrong");
   a_auto_wr_byte: assert property (auto_write_ready_flag && bus_wr && !bus_addr |=> ram_req.we
      && ram_req.wdata == $past(bus_wdata) && ram_req.addr == $past(display_ram_pointer)
      && display_ram_pointer == $past(display_ram_pointer) + 16'h1) else $error("auto write byte wrong");
   a_auto_cmd_drop: assert property (auto_write_ready_flag && cmd && bus_wdata != 8'hb2
      |=> $stable(cfg) && auto_write_ready_flag) else $error("command taken in auto mode");
   a_auto_leave: assert property ((auto_write_ready_flag || auto_read_ready_flag) && cmd &&
      bus_wdata == 8'hb2 |=> (!auto_write_ready_flag && !auto_read_ready_flag) [*4]) else $error("auto stays");
   a_peek_error: assert property ($rose(peek_copy_error_flag) |-> $past(cmd && bus_wdata == 8'he0))
      else $error("peek error without peek");
endmodule : gld_cmd_decoder_props
bind gld_cmd_decoder gld_cmd_decoder_props chk_u (.core_clk, .nrst, .bus_addr, .bus_wdata, .bus_wr, .scan_row,
   .ram_req, .cfg, .text_row_base, .graphic_row_base, .display_ram_pointer, .auto_read_ready_flag,
   .auto_write_ready_flag, .peek_copy_error_flag);

// >>> gld_pkg.sv
// Constants, encodings and carrier types of the graphic LCD command decoder.
// Assumes the host reaches it through a two-location byte port (data, command/status).
package gld_pkg;

   // Host port locations
   localparam logic       ADDR_DATA   = 1'b0;
   localparam logic       ADDR_CMD    = 1'b1;

   // Status bit positions
   localparam int         STS_CMD_OK  = 0;
   localparam int         STS_DATA_OK = 1;
   localparam int         STS_ARD_OK  = 2;
   localparam int         STS_AWR_OK  = 3;
   localparam int         STS_ERR     = 6;

   // Command codes and groups
   localparam logic [3:0] GRP_REG     = 4'h2;
   localparam logic [3:0] GRP_CTRL    = 4'h4;
   localparam logic [3:0] GRP_MODE    = 4'h8;
   localparam logic [3:0] GRP_DISP    = 4'h9;
   localparam logic [3:0] GRP_CURS    = 4'ha;
   localparam logic [3:0] GRP_AUTO    = 4'hb;
   localparam logic [3:0] GRP_DATA    = 4'hc;
   localparam logic [3:0] GRP_SCREEN  = 4'he;
   localparam logic [3:0] GRP_BIT     = 4'hf;
   localparam logic [3:0] SUB_CURSOR  = 4'h1;
   localparam logic [3:0] SUB_POINTER = 4'h4;
   localparam logic [7:0] CMD_AUTO_WR = 8'hb0;
   localparam logic [7:0] CMD_AUTO_RD = 8'hb1;
   localparam logic [7:0] CMD_AUTO_RS = 8'hb2;
   localparam logic [7:0] CMD_PEEK    = 8'he0;
   localparam logic [7:0] CMD_COPY    = 8'he8;

   typedef enum logic [1:0] {
      CMB_OR   = 2'b00,
      CMB_XOR  = 2'b01,
      CMB_ATTR = 2'b10,
      CMB_AND  = 2'b11
   } gld_comb_t;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_RD1  = 2'b01,
      ST_RD2  = 2'b10,
      ST_COPY = 2'b11
   } gld_st_t;

   typedef enum logic [2:0] {
      OP_READ = 3'b000,
      OP_AUTO = 3'b001,
      OP_BIT  = 3'b010,
      OP_PEEK = 3'b011,
      OP_COPY = 3'b100
   } gld_op_t;

   typedef struct packed {
      logic [15:0] text_home;
      logic [7:0]  text_stride;
      logic [15:0] gfx_home;
      logic [7:0]  gfx_stride;
      gld_comb_t   comb;
      logic        cg_ext;
      logic        text_en;
      logic        gfx_en;
      logic        cursor_en;
      logic        blink_en;
      logic [2:0]  cursor_lines;   // Height minus one
      logic [7:0]  cursor_x;
      logic [7:0]  cursor_y;
   } gld_cfg_t;

   typedef struct packed {
      logic [15:0] addr;
      logic [7:0]  wdata;
      logic        we;
      logic        re;
   } gld_ram_req_t;

   localparam gld_cfg_t     CFG_RESET = '0;
   localparam gld_ram_req_t RAM_IDLE  = '0;

   // Shown byte from text pattern (plain and attributed) and graphic byte
   function automatic logic [7:0] gld_combine(gld_cfg_t c, logic [7:0] txt, logic [7:0] txt_attr,
                                              logic [7:0] gfx);
      logic [7:0] t;
      logic [7:0] g;
      t = c.text_en ? txt : 8'h00;
      g = c.gfx_en ? gfx : 8'h00;
      case (c.comb)
         CMB_OR:   gld_combine = t | g;
         CMB_XOR:  gld_combine = t ^ g;
         CMB_AND:  gld_combine = t & g;
         default:  gld_combine = c.text_en ? txt_attr : 8'h00;
      endcase
   endfunction : gld_combine

endpackage : gld_pkg

// >>> gld_ram_model.sv
// Display RAM model behind the decoder: 256 bytes, address wraps.
// Assumes one request per cycle; read byte stands only in the cycle after re.
`timescale 1ns/1ps
module gld_ram_model (
   input  wire logic                  core_clk, // Clock
   input  wire gld_pkg::gld_ram_req_t req,      // Request from the decoder
   output      logic [7:0]            rdata     // Read byte
);
   logic [7:0] mem [256];
   initial begin
      rdata = 8'h5a;
      for (int i = 0; i < 256; i++) mem[i] = 8'(i) ^ 8'ha5;
   end
   // Data churns outside read cycles so a late sample cannot pass by luck
   always @(posedge core_clk) begin
      if (req.we) mem[req.addr[7:0]] <= req.wdata;
      rdata <= req.re ? mem[req.addr[7:0]] : ~rdata;
   end
endmodule : gld_ram_model

// >>> gld_row_addr.sv
// Start address of a display row: home plus row index times stride.
// Assumes a 16-bit display RAM address space; wraps modulo 64 KiB.
`timescale 1ns/1ps
module gld_row_addr (
   input  wire logic [15:0] home,     // Home address of the area
   input  wire logic [7:0]  stride,   // Bytes between rows
   input  wire logic [7:0]  row,      // Zero-based row index
   output      logic [15:0] base      // Start address of the row
);
   always_comb begin
      base = home + ({8'h00, stride} * {8'h00, row});
   end
endmodule : gld_row_addr

// >>> tb_top.sv
// Self-checking bench: host tasks drive the decoder, a RAM model sits behind it.
// Assumes RAM address bits above 7 are not decoded by the model.
`timescale 1ns/1ps
module tb_top;
   logic                  core_clk, rd_chk, rd_chk_d, pk_err;
   logic                  nrst = 1'b0, bus_addr = 1'b0, bus_wr = 1'b0, bus_rd = 1'b0, dual_screen = 1'b0;
   logic [7:0]            bus_wdata = 8'h00, bus_rdata, ram_rdata, cg_pattern = 8'h3c, scan_row = 8'h00, d;
   logic [7:0]            sh [256];
   logic [15:0]           p;
   logic [23:0]           wq [$], rq [$];
   logic [23:0]           setup [6] = '{24'h000142, 24'h200043, 24'h000040, 24'h1e0041, 24'h00009f, 24'h0000a7};
   logic [11:0]           modes [6] = '{12'h080, 12'h181, 12'h383, 12'h284, 12'h68a, 12'h589};
   gld_pkg::gld_ram_req_t ram_req;
   gld_pkg::gld_cfg_t     cfg;
   int                    n_mismatch, tests_run, cyc, seed;
   gld_cmd_decoder dut_u (.core_clk, .nrst, .bus_addr, .bus_wdata, .bus_wr, .bus_rd, .bus_rdata, .ram_req,
      .ram_rdata, .cg_pattern, .fixed_column_count(8'h04), .display_rows(8'h08), .dual_screen, .scan_row, .cfg,
      .text_row_base(), .graphic_row_base(), .display_ram_pointer(), .auto_read_ready_flag(),
      .auto_write_ready_flag(), .peek_copy_error_flag(pk_err));
   gld_ram_model ram_u (.core_clk, .req(ram_req), .rdata(ram_rdata));
   initial begin
      core_clk = 1'b0;
      forever #20 core_clk = ~core_clk;
   end
   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk(string nm, logic [23:0] e, logic [23:0] g);
      tests_run++;
      if (e !== g) begin
         n_mismatch++;
         $display("unexpected %s: expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task automatic end_of_test();
      $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : end_of_test
   task automatic wr(logic a, logic [7:0] v);
      @(posedge core_clk);
      bus_wr <= 1'b1;
      bus_addr <= a;
      bus_wdata <= v;
      @(posedge core_clk);
      bus_wr <= 1'b0;
   endtask : wr
   task automatic rd(logic a, logic c);
      @(posedge core_clk);
      bus_rd <= 1'b1;
      bus_addr <= a;
      rd_chk <= c;
      @(posedge core_clk);
      bus_rd <= 1'b0;
      @(negedge core_clk);
   endtask : rd
   // Status poll is bounded; a stuck busy shows up later as missing results
   task automatic poll(int b);
      for (int i = 0; i < 20; i++) begin
         rd(1'b1, 1'b0);
         if (bus_rdata[b] === 1'b1) break;
      end
   endtask : poll
   task automatic cmd(logic [7:0] c);
      poll(0);
      wr(1'b1, c);
   endtask : cmd
   task automatic setp(logic [15:0] a);
      wr(1'b0, a[7:0]);
      wr(1'b0, a[15:8]);
      cmd(8'h24);
      p = a;
   endtask : setp
   ////////////////////////////////////////////////////////////////////////////////
   always @(posedge core_clk) begin
      rd_chk_d <= bus_rd && rd_chk;
      scan_row <= 8'($random(seed));
      cyc <= cyc + 1;
      if (rd_chk_d) chk("read byte", rq.size() ? rq.pop_front() : 24'hxxxxxx, {16'h0, bus_rdata});
      if (ram_req.we === 1'b1) chk("ram write", wq.size() ? wq.pop_front() : 24'hxxxxxx,
         {ram_req.addr, ram_req.wdata});
      if (cyc == 6000) begin
         n_mismatch++;
         end_of_test();
      end
   end
   initial begin
      seed = 32'h1495;
      for (int i = 0; i < 256; i++) sh[i] = 8'(i) ^ 8'ha5;
      repeat (5) @(posedge core_clk);
      nrst <= 1'b1;
      foreach (setup[i]) begin
         wr(1'b0, setup[i][23:16]);
         wr(1'b0, setup[i][15:8]);
         cmd(setup[i][7:0]);
      end
      @(negedge core_clk);
      chk("layout", 24'h010020, {cfg.gfx_home, cfg.gfx_stride});
      chk("display", 24'h1ef700, {cfg.text_stride, cfg.gfx_en, cfg.text_en, cfg.cursor_en, cfg.blink_en,
         1'b0, cfg.cursor_lines, 8'h0});
      foreach (modes[i]) begin
         cmd(modes[i][7:0]);
         @(negedge core_clk);
         chk("mode", {20'h0, modes[i][11:8]}, {21'h0, cfg.cg_ext, cfg.comb});
      end
      $display("test config done");
      setp(16'h0010);
      for (int k = 0; k < 3; k++) begin
         d = 8'($random(seed));
         wr(1'b0, d);
         cmd(8'hc0 + 8'(2 * k));
         wq.push_back({p, d});
         sh[p[7:0]] = d;
         p = p + 16'(k == 0) - 16'(k == 1);
      end
      for (int k = 0; k < 3; k++) begin
         cmd(8'hc1 + 8'(2 * k));
         rq.push_back({16'h0, sh[p[7:0]]});
         repeat (2) @(posedge core_clk);
         rd(1'b0, 1'b1);
         p = p + 16'(k == 0) - 16'(k == 1);
      end
      for (int k = 0; k < 4; k++) begin
         d = 8'($random(seed));
         cmd({4'hf, d[3:0]});
         sh[p[7:0]] = d[3] ? sh[p[7:0]] | (8'h1 << d[2:0]) : sh[p[7:0]] & ~(8'h1 << d[2:0]);
         wq.push_back({p, sh[p[7:0]]});
         repeat (4) @(posedge core_clk);
      end
      $display("test data transfer done");
      cmd(8'he0);
      repeat (2) @(negedge core_clk);
      chk("peek error", 24'h1, {23'h0, pk_err});
      setp(16'h0110);
      cmd(8'he0);
      rq.push_back({16'h0, cg_pattern ^ sh[8'h10]});
      repeat (2) @(posedge core_clk);
      rd(1'b0, 1'b1);
      chk("peek clear", 24'h0, {23'h0, pk_err});
      $display("test peek done");
      setp(16'h0020);
      cmd(8'hb0);
      for (int k = 0; k < 3; k++) begin
         poll(3);
         d = 8'($random(seed));
         wr(1'b0, d);
         wq.push_back({p, d});
         p = p + 16'h1;
      end
      cmd(8'h42);
      poll(3);
      cmd(8'hb2);
      d = 8'($random(seed));
      wr(1'b0, d);
      cmd(8'hc0);
      wq.push_back({p, d});
      $display("test auto done");
      dual_screen <= 1'b1;
      cmd(8'he8);
      repeat (40) @(posedge core_clk);
      chk("pending results", 24'h0, 24'(wq.size() + rq.size()));
      $display("test copy done");
      end_of_test();
   end
endmodule : tb_top
